// >>> hdl/vtsup_defines.svh
// Purpose: constants of the vt supervision block
// Assumes: 100 MHz clock, 5 ms processing tick
// Notes: times in ns, counts derived from them
`ifndef VTSUP_DEFINES_SVH
`define VTSUP_DEFINES_SVH
`define VTSUP_CLK_PERIOD_NS 10
`define VTSUP_TICK_NS 5000000
`define VTSUP_TICK_CYC (`VTSUP_TICK_NS / `VTSUP_CLK_PERIOD_NS)
`define VTSUP_BLOCK_LEAD_NS 5000000
`define VTSUP_MAX_TIME_TICKS 360000
`define VTSUP_REC_DEPTH 12
`define VTSUP_NUM_EVT 6
`define VTSUP_CNT_W 16
`define VTSUP_MAG_W 16
`define VTSUP_ANG_W 16
`define VTSUP_TIME_W 19
`define VTSUP_STAMP_W 48
`define VTSUP_EVT_START 0
`define VTSUP_EVT_TRIP 1
`define VTSUP_EVT_BLOCK 2
`define VTSUP_EVT_LINE 3
`define VTSUP_EVT_BFUSE 4
`define VTSUP_EVT_LFUSE 5
`define VTSUP_CNT_START 0
`define VTSUP_CNT_BUS 1
`define VTSUP_CNT_LINE 2
`define VTSUP_CNT_BLOCK 3
`endif

// >>> hdl/vtsup_pkg.sv
// Purpose: types of the vt supervision block
// Assumes: constants come from vtsup_defines.svh
// Notes: none
`include "vtsup_defines.svh"
package vtsup_pkg;
	typedef enum logic [3:0] {
		VTSUP_IDLE = 4'b0001,
		VTSUP_START = 4'b0010,
		VTSUP_TRIP = 4'b0100,
		VTSUP_BLOCKED = 4'b1000
	} vtsup_state_t;
	typedef enum logic [2:0] {
		VTSUP_C_NORMAL = 3'h0,
		VTSUP_C_START = 3'h1,
		VTSUP_C_LINEFAIL = 3'h2,
		VTSUP_C_BUSFAIL = 3'h3,
		VTSUP_C_BLOCKED = 3'h4
	} vtsup_cond_t;
	typedef enum logic [2:0] {
		VTSUP_B_DEAD = 3'h0,
		VTSUP_B_SEQ_OK = 3'h1,
		VTSUP_B_SEQ_REV = 3'h2,
		VTSUP_B_SEQ_UNDEF = 3'h3,
		VTSUP_B_FAULT = 3'h4
	} vtsup_bus_t;
	typedef enum logic [1:0] {
		VTSUP_V_NONE = 2'h0,
		VTSUP_V_OK = 2'h1,
		VTSUP_V_LOW = 2'h2
	} vtsup_vstat_t;
	typedef enum logic [2:0] {
		VTSUP_M_ON = 3'h0,
		VTSUP_M_BLOCKED = 3'h1,
		VTSUP_M_TEST = 3'h2,
		VTSUP_M_TEST_BLK = 3'h3,
		VTSUP_M_OFF = 3'h4
	} vtsup_mode_t;
	typedef enum logic [1:0] {
		VTSUP_SEQ_OK = 2'h0,
		VTSUP_SEQ_REV = 2'h1,
		VTSUP_SEQ_UNDEF = 2'h2
	} vtsup_seq_t;
	typedef struct packed {
		logic [`VTSUP_STAMP_W-1:0] stamp_ms;
		logic [2:0] event_id;
		vtsup_vstat_t [3:0] vstat;
		vtsup_bus_t sys;
		logic [3:0][`VTSUP_ANG_W-1:0] ang_diff;
		logic [`VTSUP_TIME_W-1:0] remain;
		logic [2:0] set_group;
	} vtsup_rec_t;
endpackage

// >>> hdl/vtsup_rec_if.sv
// Purpose: record write and read path between core and store
// Assumes: single clock domain
// Notes: none
`timescale 1ns/1ps
interface vtsup_rec_if;
	import vtsup_pkg::*;
	logic wr;
	vtsup_rec_t wdata;
	logic [3:0] rsel;
	vtsup_rec_t rdata;
	logic [3:0] count;
	modport core(output wr, output wdata, output rsel, input rdata, input count);
	modport store(input wr, input wdata, input rsel, output rdata, output count);
endinterface

// >>> hdl/vtsup_rec_store.sv
// Purpose: ring store of the newest operation records
// Assumes: one write per cycle at most
// Notes: read select 0 is the newest record, output is registered
`timescale 1ns/1ps
module vtsup_rec_store import vtsup_pkg::*; #(
	parameter int DEPTH = `VTSUP_REC_DEPTH
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	vtsup_rec_if.store rec
);
	vtsup_rec_t mem [DEPTH];
	logic [3:0] wptr_r;
	logic [3:0] count_r;
	logic [4:0] back;
	logic [4:0] ridx;
	wire logic full = (count_r == 4'(DEPTH));
	assign back = 5'(wptr_r) + 5'(DEPTH) - 5'd1 - 5'(rec.rsel);
	assign ridx = (back >= 5'(DEPTH)) ? back - 5'(DEPTH) : back;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			wptr_r <= 4'h0;
			count_r <= 4'h0;
		end else if (rec.wr) begin
			// oldest slot is overwritten once full
			wptr_r <= (wptr_r == 4'(DEPTH - 1)) ? 4'h0 : wptr_r + 4'h1;
			count_r <= full ? count_r : count_r + 4'h1;
		end
	end
	always_ff @(posedge i_clk) begin
		if (rec.wr) begin
			mem[wptr_r] <= rec.wdata;
		end
	end
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rec.rdata <= '0;
		end else begin
			rec.rdata <= (rec.rsel < count_r) ? mem[ridx[3:0]] : '0;
		end
	end
	assign rec.count = count_r;
	chk_rec_bound: assert property (@(posedge i_clk) disable iff (!i_resetn)
		count_r <= 4'(DEPTH)) else $error("record count above depth");
	chk_rec_wrap: assert property (@(posedge i_clk) disable iff (!i_resetn)
		rec.wr && full |=> full && wptr_r != $past(wptr_r))
		else $error("full store did not advance over oldest");
endmodule

// >>> hdl/vtsup_core.sv
// Purpose: vt supervision pick-up, blocking, timing, events, counters, records
// Assumes: inputs synchronous to i_clk, magnitudes and thresholds in one scale
// Notes: pick-up, timing, flags and counters step on the 5 ms tick; events leave and records are read every cycle
`timescale 1ns/1ps
module vtsup_core import vtsup_pkg::*; #(
	parameter int TICK_CYCLES = `VTSUP_TICK_CYC,
	parameter int MAG_W = `VTSUP_MAG_W,
	parameter int ANG_W = `VTSUP_ANG_W,
	parameter int CNT_W = `VTSUP_CNT_W
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic [3:0][MAG_W-1:0] i_u_mag,
	input wire logic [3:0][ANG_W-1:0] i_ang_shift,
	input wire logic [MAG_W-1:0] i_low_pickup,
	input wire logic [MAG_W-1:0] i_high_detect,
	input wire logic [ANG_W-1:0] i_ang_limit,
	input wire vtsup_seq_t i_seq,
	input wire logic i_block,
	input wire logic [`VTSUP_TIME_W-1:0] i_op_delay,
	input wire vtsup_mode_t i_mode,
	input wire logic i_force_en,
	input wire vtsup_cond_t i_force_cond,
	input wire logic i_bus_fuse_fail,
	input wire logic i_line_fuse_fail,
	input wire logic i_bus_fuse_chk,
	input wire logic i_line_fuse_chk,
	input wire logic [`VTSUP_NUM_EVT-1:0] i_evt_on_en,
	input wire logic [`VTSUP_NUM_EVT-1:0] i_evt_off_en,
	input wire logic [`VTSUP_STAMP_W-1:0] i_stamp_ms,
	input wire logic [2:0] i_set_group,
	input wire logic i_cnt_clear,
	input wire logic [3:0] i_rec_sel,
	output logic o_tick,
	output logic o_start,
	output logic o_trip,
	output logic o_blocked,
	output vtsup_cond_t o_cond,
	output vtsup_bus_t o_bus_status,
	output vtsup_mode_t o_behaviour,
	output logic [`VTSUP_TIME_W-1:0] o_expected_time,
	output logic signed [`VTSUP_TIME_W:0] o_remaining,
	output logic o_evt_valid,
	output logic [2:0] o_evt_id,
	output logic o_evt_on,
	output logic [`VTSUP_STAMP_W-1:0] o_evt_stamp,
	output logic [3:0][CNT_W-1:0] o_counts,
	output vtsup_rec_t o_rec,
	output logic [3:0] o_rec_count
);
	localparam int NE = `VTSUP_NUM_EVT;
	function automatic logic [3:0] first_set(input logic [2*NE-1:0] v);
		logic [3:0] idx;
		idx = 4'h0;
		for (int i = 2*NE-1; i >= 0; i--) begin
			if (v[i]) begin
				idx = 4'(i);
			end
		end
		return idx;
	endfunction
	function automatic vtsup_vstat_t volt_state(input logic [MAG_W-1:0] u,
		input logic [MAG_W-1:0] lo, input logic [MAG_W-1:0] hi);
		return (u < lo) ? VTSUP_V_NONE : ((u < hi) ? VTSUP_V_LOW : VTSUP_V_OK);
	endfunction

	logic [31:0] tick_cnt_r;
	logic tick;
	vtsup_state_t st_r;
	vtsup_state_t st_nxt;
	logic blk_r;
	logic [`VTSUP_TIME_W-1:0] timer_r;
	logic [`VTSUP_TIME_W-1:0] timer_nxt;
	logic [NE-1:0] flag_r;
	logic [NE-1:0] flag_nxt;
	logic [NE-1:0] pend_on_r;
	logic [NE-1:0] pend_off_r;
	logic [`VTSUP_STAMP_W-1:0] stamp_r;
	logic [3:0][CNT_W-1:0] cnt_r;
	vtsup_rec_if rec_if();

	assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			tick_cnt_r <= 32'h0000_0000;
		end else begin
			tick_cnt_r <= tick ? 32'h0000_0000 : tick_cnt_r + 32'h0000_0001;
		end
	end

	// decode of pick-up
	wire logic [2:0] below;
	wire logic [2:0] above;
	wire logic [2:0] shifted;
	genvar g;
	for (g = 0; g < 3; g++) begin : g_phase
		assign below[g] = i_u_mag[g] < i_low_pickup;
		assign above[g] = i_u_mag[g] > i_high_detect;
		assign shifted[g] = i_ang_shift[g] >= i_ang_limit;
	end
	wire logic two_high = (above[0] & above[1]) | (above[0] & above[2]) | (above[1] & above[2]);
	wire logic volt_pick = (|below) | two_high;
	// a steady angle holds pick-up off; no phase moved by the limit
	wire logic pickup = volt_pick & (|shifted);
	wire logic mode_off = (i_mode == VTSUP_M_OFF);
	wire logic mode_blk = (i_mode == VTSUP_M_BLOCKED) | (i_mode == VTSUP_M_TEST_BLK);
	// sampled level used throughout the tick
	wire logic blk_s = tick ? (i_block | mode_blk) : blk_r;
	wire logic bus_dead = &below;
	wire logic line_fail = (i_u_mag[3] < i_low_pickup) & ~bus_dead;
	wire logic [`VTSUP_TIME_W-1:0] timer_inc = timer_r + `VTSUP_TIME_W'(1);

	always_comb begin
		st_nxt = st_r;
		timer_nxt = timer_r;
		case (st_r)
			VTSUP_IDLE: begin
				if (pickup) begin
					st_nxt = blk_s ? VTSUP_BLOCKED : VTSUP_START;
					timer_nxt = '0;
				end
			end
			VTSUP_START: begin
				if (!pickup) begin
					st_nxt = VTSUP_IDLE;
				end else if (blk_s) begin
					st_nxt = VTSUP_BLOCKED;
				end else begin
					timer_nxt = timer_inc;
					if (timer_inc >= i_op_delay) begin
						st_nxt = VTSUP_TRIP;
					end
				end
			end
			VTSUP_TRIP: begin
				if (!pickup) begin
					st_nxt = VTSUP_IDLE;
				end else if (blk_s) begin
					st_nxt = VTSUP_BLOCKED;
				end
			end
			VTSUP_BLOCKED: begin
				if (!pickup) begin
					st_nxt = VTSUP_IDLE;
				end else if (!blk_s) begin
					st_nxt = VTSUP_START;
					timer_nxt = '0;
				end
			end
			default: st_nxt = VTSUP_IDLE;
		endcase
		if (mode_off) begin
			st_nxt = VTSUP_IDLE;
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= VTSUP_IDLE;
			timer_r <= '0;
			blk_r <= 1'b0;
		end else if (tick) begin
			st_r <= st_nxt;
			timer_r <= timer_nxt;
			blk_r <= i_block | mode_blk;
		end
	end

	assign flag_nxt[`VTSUP_EVT_START] = (st_nxt == VTSUP_START) | (st_nxt == VTSUP_TRIP);
	assign flag_nxt[`VTSUP_EVT_TRIP] = (st_nxt == VTSUP_TRIP);
	assign flag_nxt[`VTSUP_EVT_BLOCK] = (st_nxt == VTSUP_BLOCKED);
	assign flag_nxt[`VTSUP_EVT_LINE] = line_fail & ~mode_off;
	assign flag_nxt[`VTSUP_EVT_BFUSE] = i_bus_fuse_fail & i_bus_fuse_chk & ~mode_off;
	assign flag_nxt[`VTSUP_EVT_LFUSE] = i_line_fuse_fail & i_line_fuse_chk & ~mode_off;
	wire logic [NE-1:0] rise = tick ? (flag_nxt & ~flag_r) : '0;
	wire logic [NE-1:0] fall = tick ? (~flag_nxt & flag_r) : '0;

	// one event leaves per cycle; an edge on the grant cycle is kept
	wire logic [2*NE-1:0] pend_all = {pend_off_r, pend_on_r};
	wire logic [3:0] grant = first_set(pend_all);
	wire logic [2*NE-1:0] grant_oh = (|pend_all) ? ((2*NE)'(1) << grant) : '0;
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			flag_r <= '0;
			pend_on_r <= '0;
			pend_off_r <= '0;
			stamp_r <= '0;
		end else begin
			if (tick) begin
				flag_r <= flag_nxt;
				stamp_r <= i_stamp_ms;
			end
			pend_on_r <= (pend_on_r & ~grant_oh[NE-1:0]) | (rise & i_evt_on_en);
			pend_off_r <= (pend_off_r & ~grant_oh[2*NE-1:NE]) | (fall & i_evt_off_en);
		end
	end

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_evt_valid <= 1'b0;
			o_evt_id <= 3'h0;
			o_evt_on <= 1'b0;
			o_evt_stamp <= '0;
		end else begin
			o_evt_valid <= |pend_all;
			o_evt_id <= (grant >= 4'(NE)) ? 3'(grant - 4'(NE)) : grant[2:0];
			o_evt_on <= (grant < 4'(NE));
			o_evt_stamp <= stamp_r;
		end
	end

	// counters follow rising edges of start, trip, line fail, blocked
	wire logic [3:0] cnt_hit = {rise[`VTSUP_EVT_BLOCK], rise[`VTSUP_EVT_LINE],
		rise[`VTSUP_EVT_TRIP], rise[`VTSUP_EVT_START]};
	for (g = 0; g < 4; g++) begin : g_cnt
		always_ff @(posedge i_clk or negedge i_resetn) begin
			if (!i_resetn) begin
				cnt_r[g] <= '0;
			end else if (cnt_hit[g]) begin
				cnt_r[g] <= i_cnt_clear ? CNT_W'(1) : cnt_r[g] + CNT_W'(1);
			end else if (i_cnt_clear) begin
				cnt_r[g] <= '0;
			end
		end
	end

	wire vtsup_bus_t bus_now = bus_dead ? VTSUP_B_DEAD : (pickup ? VTSUP_B_FAULT :
		(i_seq == VTSUP_SEQ_OK) ? VTSUP_B_SEQ_OK :
		(i_seq == VTSUP_SEQ_REV) ? VTSUP_B_SEQ_REV : VTSUP_B_SEQ_UNDEF);
	wire vtsup_cond_t cond_now = i_force_en ? i_force_cond :
		(st_nxt == VTSUP_BLOCKED) ? VTSUP_C_BLOCKED :
		(st_nxt == VTSUP_TRIP) ? VTSUP_C_BUSFAIL :
		line_fail & ~mode_off ? VTSUP_C_LINEFAIL :
		(st_nxt == VTSUP_START) ? VTSUP_C_START : VTSUP_C_NORMAL;
	wire logic signed [`VTSUP_TIME_W:0] remain_now =
		$signed({1'b0, i_op_delay}) - $signed({1'b0, timer_nxt});
	wire logic [2:0] rec_rise = rise[2:0];
	wire logic [2:0] rec_id = rec_rise[`VTSUP_EVT_START] ? 3'(`VTSUP_EVT_START) :
		rec_rise[`VTSUP_EVT_TRIP] ? 3'(`VTSUP_EVT_TRIP) : 3'(`VTSUP_EVT_BLOCK);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rec_if.wr <= 1'b0;
			rec_if.wdata <= '0;
		end else begin
			rec_if.wr <= |rec_rise;
			if (|rec_rise) begin
				rec_if.wdata.stamp_ms <= i_stamp_ms;
				rec_if.wdata.event_id <= rec_id;
				for (int i = 0; i < 4; i++) begin
					rec_if.wdata.vstat[i] <= volt_state(i_u_mag[i], i_low_pickup, i_high_detect);
					rec_if.wdata.ang_diff[i] <= i_ang_shift[i];
				end
				rec_if.wdata.sys <= bus_now;
				rec_if.wdata.remain <= remain_now[`VTSUP_TIME_W] ? '0 :
					remain_now[`VTSUP_TIME_W-1:0];
				rec_if.wdata.set_group <= i_set_group;
			end
		end
	end
	assign rec_if.rsel = i_rec_sel;

	vtsup_rec_store #(.DEPTH(`VTSUP_REC_DEPTH)) u_store (
		.i_clk(i_clk),
		.i_resetn(i_resetn),
		.rec(rec_if.store)
	);

	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_tick <= 1'b0;
			o_start <= 1'b0;
			o_trip <= 1'b0;
			o_blocked <= 1'b0;
			o_cond <= VTSUP_C_NORMAL;
			o_bus_status <= VTSUP_B_DEAD;
			o_behaviour <= VTSUP_M_ON;
			o_expected_time <= '0;
			o_remaining <= '0;
			o_counts <= '0;
			o_rec <= '0;
			o_rec_count <= 4'h0;
		end else begin
			o_tick <= tick;
			o_behaviour <= i_mode;
			o_expected_time <= i_op_delay;
			o_counts <= cnt_r;
			o_rec <= rec_if.rdata;
			o_rec_count <= rec_if.count;
			if (tick) begin
				o_start <= flag_nxt[`VTSUP_EVT_START];
				o_trip <= flag_nxt[`VTSUP_EVT_TRIP];
				o_blocked <= flag_nxt[`VTSUP_EVT_BLOCK];
				o_cond <= cond_now;
				o_bus_status <= bus_now;
				o_remaining <= (st_nxt == VTSUP_START || st_nxt == VTSUP_TRIP) ?
					remain_now : '0;
			end
		end
	end

	sequence s_idle_pick(logic b);
		tick && st_r == VTSUP_IDLE && pickup && !mode_off && blk_s == b;
	endsequence
	chk_block_held: assert property (@(posedge i_clk) disable iff (!i_resetn)
		!tick |=> $stable(blk_r)) else $error("block sample moved inside a tick");
	chk_start_entry: assert property (@(posedge i_clk) disable iff (!i_resetn)
		s_idle_pick(1'b0) |=> o_start && st_r == VTSUP_START && timer_r == '0)
		else $error("unblocked pick-up did not start");
	chk_blocked_entry: assert property (@(posedge i_clk) disable iff (!i_resetn)
		s_idle_pick(1'b1) |=> o_blocked && !o_start && st_r == VTSUP_BLOCKED)
		else $error("blocked pick-up still started");
	chk_start_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick && o_start && blk_s |=> !o_start) else $error("start held under block");
	chk_dt_operate: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick && st_r == VTSUP_START && pickup && !blk_s && !mode_off &&
		timer_inc >= i_op_delay |=> o_trip) else $error("definite delay missed");
	// a pending bit may only appear for an edge whose selection was set at the tick
	chk_evt_select: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick |=> ((pend_on_r & ~$past(pend_on_r) & ~$past(i_evt_on_en)) == '0) &&
		((pend_off_r & ~$past(pend_off_r) & ~$past(i_evt_off_en)) == '0))
		else $error("event kept without selection");
	chk_cnt_start: assert property (@(posedge i_clk) disable iff (!i_resetn)
		rise[`VTSUP_EVT_START] && !i_cnt_clear |=> cnt_r[0] == $past(cnt_r[0]) + CNT_W'(1))
		else $error("start counter did not step");
	chk_remain_step: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick && st_r == VTSUP_START && st_nxt == VTSUP_START && o_remaining != '0
		|=> o_remaining == $past(o_remaining) - 1) else $error("remaining time not stepping");
	chk_record_on: assert property (@(posedge i_clk) disable iff (!i_resetn)
		tick && flag_nxt[`VTSUP_EVT_BLOCK] && !flag_r[`VTSUP_EVT_BLOCK] ##1 1'b1
		|-> rec_if.wr) else $error("blocked edge made no record");
endmodule

// >>> dv/vtsup_far.sv
// Purpose: blocking matrix source and event recorder beside the core
// Assumes: block request comes from the bench, one event per cycle
// Notes: glitch mode pulses the block line only between ticks
`timescale 1ns/1ps
module vtsup_far (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_tick,
	input wire logic i_blk_req,
	input wire logic i_glitch,
	input wire logic i_evt_valid,
	input wire logic [2:0] i_evt_id,
	input wire logic i_evt_on,
	output logic o_block,
	output logic [11:0][7:0] o_evt_cnt
);
	logic blk_r;
	logic [4:0] ph_r;
	// applied one cycle after a tick, so it leads the next sample by all but one cycle of a tick
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			blk_r <= 1'b0;
			ph_r <= 5'h0;
			o_evt_cnt <= '0;
		end else begin
			if (i_tick) begin
				blk_r <= i_blk_req;
			end
			ph_r <= i_tick ? 5'h0 : ph_r + 5'h1;
			if (i_evt_valid) begin
				o_evt_cnt[{i_evt_id, i_evt_on}] <= o_evt_cnt[{i_evt_id, i_evt_on}] + 8'h01;
			end
		end
	end
	// pulse stays clear of the sampling edge
	assign o_block = blk_r | (i_glitch && ph_r > 5'h2 && ph_r < 5'hc);
endmodule

// >>> dv/vtsup_core_bench.sv
// Purpose: self-checking bench of the vt supervision core
// Assumes: short tick of 20 cycles, thresholds fixed below
// Notes: u1 below low is the usual pick-up stimulus
`timescale 1ns/1ps
module vtsup_core_bench import vtsup_pkg::*;;
	localparam int TK = 20;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic [3:0][15:0] u_mag;
	logic [3:0][15:0] ang_sh;
	logic [18:0] op_delay;
	vtsup_mode_t mode;
	vtsup_cond_t force_cond;
	vtsup_seq_t seq;
	logic force_en, bfuse, lfuse, clr, blk_req, glitch, blk;
	logic [5:0] evt_on, evt_off;
	logic [47:0] stamp;
	logic [2:0] grp;
	logic [3:0] rsel;
	logic tick, start, trip, blocked, ev_v, ev_on;
	vtsup_cond_t cond;
	vtsup_bus_t bus;
	vtsup_mode_t beh;
	logic [18:0] exp_t;
	logic signed [19:0] remain;
	logic [2:0] ev_id;
	logic [47:0] ev_st;
	logic [3:0][15:0] counts;
	vtsup_rec_t rec;
	logic [3:0] rec_cnt;
	logic [11:0][7:0] ev_cnt;
	int err_count = 0;
	int n_tests = 0;

	always #5 i_clk = ~i_clk;

	vtsup_core #(.TICK_CYCLES(TK)) dut (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_u_mag(u_mag), .i_ang_shift(ang_sh),
		.i_low_pickup(16'h0100), .i_high_detect(16'h0800), .i_ang_limit(16'h0010),
		.i_seq(seq), .i_block(blk), .i_op_delay(op_delay), .i_mode(mode),
		.i_force_en(force_en), .i_force_cond(force_cond), .i_bus_fuse_fail(bfuse),
		.i_line_fuse_fail(lfuse), .i_bus_fuse_chk(1'b1), .i_line_fuse_chk(1'b1),
		.i_evt_on_en(evt_on), .i_evt_off_en(evt_off), .i_stamp_ms(stamp),
		.i_set_group(grp), .i_cnt_clear(clr), .i_rec_sel(rsel), .o_tick(tick),
		.o_start(start), .o_trip(trip), .o_blocked(blocked), .o_cond(cond),
		.o_bus_status(bus), .o_behaviour(beh), .o_expected_time(exp_t),
		.o_remaining(remain), .o_evt_valid(ev_v), .o_evt_id(ev_id), .o_evt_on(ev_on),
		.o_evt_stamp(ev_st), .o_counts(counts), .o_rec(rec), .o_rec_count(rec_cnt));

	vtsup_far far (
		.i_clk(i_clk), .i_resetn(i_resetn), .i_tick(tick), .i_blk_req(blk_req),
		.i_glitch(glitch), .i_evt_valid(ev_v), .i_evt_id(ev_id), .i_evt_on(ev_on),
		.o_block(blk), .o_evt_cnt(ev_cnt));

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// waits for n processing ticks, outputs settled on return
	task automatic tk(input int n);
		int w;
		repeat (n) begin
			w = 0;
			do begin
				@(posedge i_clk);
				#1;
				w++;
			end while (tick !== 1'b1 && w < 3 * TK);
		end
	endtask

	task automatic pu(input logic on);
		@(posedge i_clk);
		u_mag[0] <= on ? 16'h0050 : 16'h0400;
	endtask

	// record path needs store and output register stages
	task automatic rd(input logic [3:0] s);
		@(posedge i_clk);
		rsel <= s;
		repeat (4) @(posedge i_clk);
		#1;
	endtask

	initial begin
		#100_000;
		err_count++;
		finish_test();
	end

	initial begin
		u_mag = {4{16'h0400}};
		ang_sh = {4{16'h0020}};
		op_delay = 19'h0_0004;
		mode = VTSUP_M_ON;
		force_cond = VTSUP_C_NORMAL;
		seq = VTSUP_SEQ_OK;
		{force_en, bfuse, lfuse, clr, blk_req, glitch} = 6'h00;
		evt_on = 6'h3f;
		evt_off = 6'h3e;
		stamp = 48'h0000_0000_1000;
		grp = 3'h5;
		rsel = 4'h0;
		repeat (10) @(posedge i_clk);
		#1;
		chk(counts, 64'h0);
		chk(rec_cnt, 4'h0);
		@(posedge i_clk);
		i_resetn <= 1'b1;
		for (int m = 0; m < 5; m++) begin
			@(posedge i_clk);
			mode <= vtsup_mode_t'(m);
			op_delay <= (m == 4) ? 19'h5_7e40 : 19'(m);
			repeat (2) @(posedge i_clk);
			#1;
			chk(beh, 64'(m));
			chk(exp_t, (m == 4) ? 64'h5_7e40 : 64'(m));
		end
		@(posedge i_clk);
		mode <= VTSUP_M_ON;
		op_delay <= 19'h0_0004;
		for (int c = 0; c < 5; c++) begin
			@(posedge i_clk);
			force_en <= 1'b1;
			force_cond <= vtsup_cond_t'(c);
			tk(1);
			chk(cond, 64'(c));
		end
		for (int s = 2; s >= 0; s--) begin
			@(posedge i_clk);
			force_en <= 1'b0;
			seq <= vtsup_seq_t'(s);
			tk(1);
			chk(bus, 64'(s + 1));
		end
		@(posedge i_clk);
		ang_sh <= {4{16'h0008}};
		u_mag[0] <= 16'h0050;
		tk(1);
		chk(start, 1'b0);
		@(posedge i_clk);
		ang_sh <= {4{16'h0020}};
		u_mag[0] <= 16'h0900;
		tk(1);
		chk(start, 1'b0);
		@(posedge i_clk);
		u_mag[1] <= 16'h0900;
		tk(1);
		chk(start, 1'b1);
		chk(cond, VTSUP_C_START);
		@(posedge i_clk);
		u_mag <= {4{16'h0400}};
		clr <= 1'b1;
		@(posedge i_clk);
		clr <= 1'b0;
		tk(1);
		chk(counts, 64'h0);
		pu(1'b1);
		tk(1);
		chk(start, 1'b1);
		chk(remain, 64'h4);
		chk(bus, VTSUP_B_FAULT);
		for (int k = 3; k >= 0; k--) begin
			chk(trip, 1'b0);
			tk(1);
			chk(remain, 64'(k));
		end
		chk(trip, 1'b1);
		chk(cond, VTSUP_C_BUSFAIL);
		rd(4'h0);
		chk(rec.event_id, 64'h1);
		chk(rec.stamp_ms, stamp);
		chk(rec.sys, VTSUP_B_FAULT);
		chk(rec.set_group, grp);
		pu(1'b0);
		tk(1);
		chk(start, 1'b0);
		chk(cond, VTSUP_C_NORMAL);
		chk(remain, 64'h0);
		@(posedge i_clk);
		blk_req <= 1'b1;
		tk(2);
		pu(1'b1);
		tk(1);
		chk(blocked, 1'b1);
		chk(start, 1'b0);
		chk(cond, VTSUP_C_BLOCKED);
		tk(1);
		chk(remain, 64'h0);
		rd(4'h0);
		chk(rec.event_id, 64'h2);
		pu(1'b0);
		blk_req <= 1'b0;
		tk(3);
		chk(counts, {16'h1, 16'h0, 16'h1, 16'h1});
		@(posedge i_clk);
		glitch <= 1'b1;
		u_mag[0] <= 16'h0050;
		tk(2);
		chk(start, 1'b1);
		@(posedge i_clk);
		blk_req <= 1'b1;
		tk(2);
		chk(start, 1'b0);
		chk(remain, 64'h0);
		pu(1'b0);
		{blk_req, glitch} <= 2'b00;
		bfuse <= 1'b1;
		lfuse <= 1'b1;
		u_mag[3] <= 16'h0050;
		tk(3);
		@(posedge i_clk);
		{bfuse, lfuse} <= 2'b00;
		u_mag[3] <= 16'h0400;
		tk(2);
		chk(ev_cnt[1], 8'h03);
		chk(ev_cnt[0], 8'h00);
		chk(ev_cnt[3], 8'h01);
		chk(ev_cnt[2], 8'h01);
		for (int e = 3; e < 6; e++) begin
			chk(ev_cnt[2 * e + 1], 8'h01);
			chk(ev_cnt[2 * e], 8'h01);
		end
		for (int r = 0; r < 13; r++) begin
			@(posedge i_clk);
			stamp <= 48'h0000_0000_2000 + 48'(r);
			u_mag[0] <= 16'h0050;
			tk(1);
			pu(1'b0);
			tk(1);
		end
		chk(rec_cnt, 4'hc);
		rd(4'h0);
		chk(rec.stamp_ms, 48'h0000_0000_200c);
		chk(rec.event_id, 64'h0);
		chk(rec.remain, 64'h4);
		chk(rec.ang_diff[0], 64'h20);
		chk(rec.vstat[0], VTSUP_V_NONE);
		rd(4'hb);
		chk(rec.stamp_ms, 48'h0000_0000_2001);
		finish_test();
	end
endmodule
